// File: core/ddc_ctrl.sv
// Controller end: turns user commands into pin states
`timescale 1ns/10ps
`include "ddc_defs.svh"

module ddc_ctrl #(
	parameter int PD_MAX_CLKS = `DDC_PD_MAX_CLKS
) (
	input  wire logic                       ref_clk,
	input  wire logic                       arst_n,
	ddc_if.ctrl                             pins,
	input  wire logic                       req_valid,
	input  wire ddc_pkg::ddc_cmd_t          req_cmd,
	input  wire logic [`DDC_BANK_BITS-1:0]  req_bank,
	input  wire logic [`DDC_ADDR_BITS-1:0]  req_addr,
	output logic                            req_ready,
	output ddc_pkg::ddc_pwr_t               pwr_state,
	output logic                            pd_forced
);

	typedef struct packed {
		logic                       cs_n;
		logic                       ras_n;
		logic                       cas_n;
		logic                       we_n;
		logic                       cke;
		logic [`DDC_BANK_BITS-1:0]  ba;
		logic [`DDC_ADDR_BITS-1:0]  addr;
		logic                       ready;
		ddc_pkg::ddc_pwr_t          pwr;
		logic [1:0]                 busy;
		logic [15:0]                pd_cnt;
		logic                       forced;
	} ddc_ctrl_st_t;

	ddc_ctrl_st_t st_r;
	ddc_ctrl_st_t st_nxt;
	logic         take;

	assign take = req_valid & st_r.ready;

	always_comb begin
		st_nxt        = st_r;
		st_nxt.cs_n   = 1'b1;
		st_nxt.forced = 1'b0;
		st_nxt.ba     = req_bank;
		st_nxt.addr   = req_addr;
		if (st_r.busy != 2'h0)
			st_nxt.busy = st_r.busy - 2'h1;
		case (st_r.pwr)
			ddc_pkg::DDC_PW_ON: begin
				if (take) begin
					st_nxt.cs_n = 1'b0;
					{st_nxt.ras_n, st_nxt.cas_n, st_nxt.we_n} = 3'h7;
					case (req_cmd)
						ddc_pkg::DDC_MODE_LOAD: {st_nxt.ras_n, st_nxt.cas_n, st_nxt.we_n} = 3'h0;
						ddc_pkg::DDC_REFRESH:   {st_nxt.ras_n, st_nxt.cas_n, st_nxt.we_n} = 3'h1;
						ddc_pkg::DDC_ACTIVATE:  {st_nxt.ras_n, st_nxt.cas_n, st_nxt.we_n} = 3'h3;
						ddc_pkg::DDC_PRE_BANK, ddc_pkg::DDC_PRE_ALL: begin
							{st_nxt.ras_n, st_nxt.cas_n, st_nxt.we_n} = 3'h2;
							st_nxt.addr[`DDC_A10_POS] = (req_cmd == ddc_pkg::DDC_PRE_ALL);
						end
						ddc_pkg::DDC_READ, ddc_pkg::DDC_READ_AP: begin
							{st_nxt.ras_n, st_nxt.cas_n, st_nxt.we_n} = 3'h5;
							st_nxt.addr[`DDC_A10_POS] = (req_cmd == ddc_pkg::DDC_READ_AP);
							st_nxt.busy = 2'(`DDC_BURST_CLKS - 1);
						end
						ddc_pkg::DDC_WRITE, ddc_pkg::DDC_WRITE_AP: begin
							{st_nxt.ras_n, st_nxt.cas_n, st_nxt.we_n} = 3'h4;
							st_nxt.addr[`DDC_A10_POS] = (req_cmd == ddc_pkg::DDC_WRITE_AP);
							st_nxt.busy = 2'(`DDC_BURST_CLKS - 1);
						end
						ddc_pkg::DDC_SREF_ENTER: begin
							{st_nxt.ras_n, st_nxt.cas_n, st_nxt.we_n} = 3'h1;
							st_nxt.cke = 1'b0;
							st_nxt.pwr = ddc_pkg::DDC_PW_SREF;
						end
						ddc_pkg::DDC_PD_ENTER: begin
							st_nxt.cke    = 1'b0;
							st_nxt.pwr    = ddc_pkg::DDC_PW_DOWN;
							st_nxt.pd_cnt = 16'h0000;
						end
						ddc_pkg::DDC_DESEL: st_nxt.cs_n = 1'b1;
						default: ;
					endcase
				end
			end
			ddc_pkg::DDC_PW_DOWN: begin
				st_nxt.pd_cnt = st_r.pd_cnt + 16'h0001;
				// No refresh while down, so the stay is capped
				if ((take && req_cmd == ddc_pkg::DDC_LOW_EXIT) ||
					st_r.pd_cnt >= 16'(PD_MAX_CLKS - 1)) begin
					st_nxt.cke    = 1'b1;
					st_nxt.pwr    = ddc_pkg::DDC_PW_ON;
					st_nxt.forced = !(take && req_cmd == ddc_pkg::DDC_LOW_EXIT);
				end
			end
			ddc_pkg::DDC_PW_SREF: begin
				if (take && req_cmd == ddc_pkg::DDC_LOW_EXIT) begin
					st_nxt.cke = 1'b1;
					st_nxt.pwr = ddc_pkg::DDC_PW_ON;
				end
			end
			default: st_nxt.pwr = ddc_pkg::DDC_PW_ON;
		endcase
		st_nxt.ready = (st_nxt.busy == 2'h0);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1,
				ba: '0, addr: '0, ready: 1'b1, pwr: ddc_pkg::DDC_PW_ON,
				busy: 2'h0, pd_cnt: 16'h0000, forced: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pins.cs_n  = st_r.cs_n;
	assign pins.ras_n = st_r.ras_n;
	assign pins.cas_n = st_r.cas_n;
	assign pins.we_n  = st_r.we_n;
	assign pins.cke   = st_r.cke;
	assign pins.ba    = st_r.ba;
	assign pins.addr  = st_r.addr;
	assign req_ready  = st_r.ready;
	assign pwr_state  = st_r.pwr;
	assign pd_forced  = st_r.forced;

endmodule

// File: core/ddc_defs.svh
// Offsets, field positions and timing counts of the command decoder
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH

`define DDC_ADDR_BITS     14
`define DDC_BANK_BITS     3
`define DDC_A10_POS       10
`define DDC_MR_SEL_BITS   2
`define DDC_MR_COUNT      4
`define DDC_MR_RESET      14'h0000
`define DDC_BURST_LEN     4
`define DDC_BURST_CLKS    (`DDC_BURST_LEN / 2)
`define DDC_CLK_NS        40
`define DDC_PD_MAX_NS     7800
`define DDC_PD_MAX_CLKS   (`DDC_PD_MAX_NS / `DDC_CLK_NS)

`endif

// File: core/ddc_dev.sv
// Device end: samples the pins and decodes each command
`timescale 1ns/10ps
`include "ddc_defs.svh"

module ddc_dev (
	input  wire logic                       ref_clk,
	input  wire logic                       arst_n,
	ddc_if.dev                              pins,
	output ddc_pkg::ddc_cmd_t               cmd,
	output logic                            cmd_stb,
	output logic [`DDC_BANK_BITS-1:0]       cmd_bank,
	output logic [`DDC_ADDR_BITS-1:0]       cmd_addr,
	output ddc_pkg::ddc_pwr_t               pwr_state,
	output logic                            burst_busy,
	output logic                            cmd_violation,
	output logic [`DDC_ADDR_BITS-1:0]       mode_reg [`DDC_MR_COUNT]
);

	typedef struct packed {
		logic                                          cke_prev;
		ddc_pkg::ddc_cmd_t                             cmd;
		logic                                          stb;
		logic [`DDC_BANK_BITS-1:0]                     bank;
		logic [`DDC_ADDR_BITS-1:0]                     addr;
		ddc_pkg::ddc_pwr_t                             pwr;
		logic [1:0]                                    busy;
		logic                                          bsy;
		logic                                          viol;
		logic [`DDC_MR_COUNT-1:0][`DDC_ADDR_BITS-1:0]  mr;
	} ddc_dev_st_t;

	ddc_dev_st_t       st_r;
	ddc_dev_st_t       st_nxt;
	ddc_pkg::ddc_cmd_t dec;
	logic              idle_enc;

	// Decode of RAS/CAS/WE with the clock enable held high
	function automatic ddc_pkg::ddc_cmd_t ddc_decode(input logic [2:0] rcw,
		input logic a10);
		case (rcw)
			3'h0: ddc_decode = ddc_pkg::DDC_MODE_LOAD;
			3'h1: ddc_decode = ddc_pkg::DDC_REFRESH;
			3'h3: ddc_decode = ddc_pkg::DDC_ACTIVATE;
			3'h2: ddc_decode = a10 ? ddc_pkg::DDC_PRE_ALL : ddc_pkg::DDC_PRE_BANK;
			3'h5: ddc_decode = a10 ? ddc_pkg::DDC_READ_AP : ddc_pkg::DDC_READ;
			3'h4: ddc_decode = a10 ? ddc_pkg::DDC_WRITE_AP : ddc_pkg::DDC_WRITE;
			3'h7: ddc_decode = ddc_pkg::DDC_NOP;
			default: ddc_decode = ddc_pkg::DDC_ILLEGAL;
		endcase
	endfunction

	assign idle_enc = pins.cs_n | ({pins.ras_n, pins.cas_n, pins.we_n} == 3'h7);

	always_comb begin
		dec = ddc_pkg::DDC_NOP;
		case ({st_r.cke_prev, pins.cke})
			2'b11: begin
				if (pins.cs_n)
					dec = ddc_pkg::DDC_DESEL;
				else
					dec = ddc_decode({pins.ras_n, pins.cas_n, pins.we_n},
						pins.addr[`DDC_A10_POS]);
			end
			2'b10: begin
				if (!pins.cs_n && {pins.ras_n, pins.cas_n, pins.we_n} == 3'h1)
					dec = ddc_pkg::DDC_SREF_ENTER;
				else if (idle_enc)
					dec = ddc_pkg::DDC_PD_ENTER;
				else
					dec = ddc_pkg::DDC_ILLEGAL;
			end
			2'b01: dec = idle_enc ? ddc_pkg::DDC_LOW_EXIT : ddc_pkg::DDC_ILLEGAL;
			default: dec = ddc_pkg::DDC_NOP;
		endcase
	end

	// Everything is taken at the rising edge only
	always_comb begin
		st_nxt          = st_r;
		st_nxt.cke_prev = pins.cke;
		st_nxt.stb      = 1'b0;
		st_nxt.viol     = 1'b0;
		if (st_r.busy != 2'h0)
			st_nxt.busy = st_r.busy - 2'h1;
		if (st_r.busy != 2'h0 && dec != ddc_pkg::DDC_NOP && dec != ddc_pkg::DDC_DESEL) begin
			// A short burst cannot be cut, so the command is dropped
			st_nxt.viol = 1'b1;
		end else if (dec == ddc_pkg::DDC_ILLEGAL) begin
			st_nxt.viol = 1'b1;
		end else if (!(dec == ddc_pkg::DDC_NOP && !(st_r.cke_prev & pins.cke))) begin
			st_nxt.stb  = 1'b1;
			st_nxt.cmd  = dec;
			st_nxt.bank = pins.ba;
			st_nxt.addr = pins.addr;
			case (dec)
				ddc_pkg::DDC_MODE_LOAD:
					st_nxt.mr[pins.ba[`DDC_MR_SEL_BITS-1:0]] = pins.addr;
				ddc_pkg::DDC_READ, ddc_pkg::DDC_READ_AP,
				ddc_pkg::DDC_WRITE, ddc_pkg::DDC_WRITE_AP:
					st_nxt.busy = 2'(`DDC_BURST_CLKS - 1);
				ddc_pkg::DDC_SREF_ENTER: st_nxt.pwr = ddc_pkg::DDC_PW_SREF;
				// Refresh stalls while down; the controller caps the stay
				ddc_pkg::DDC_PD_ENTER: st_nxt.pwr = ddc_pkg::DDC_PW_DOWN;
				ddc_pkg::DDC_LOW_EXIT: st_nxt.pwr = ddc_pkg::DDC_PW_ON;
				default: ;
			endcase
		end
		// Busy flag kept in a flop so the pin needs no compare
		st_nxt.bsy = (st_nxt.busy != 2'h0);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '{cke_prev: 1'b0, cmd: ddc_pkg::DDC_NOP, stb: 1'b0, bank: '0,
				addr: '0, pwr: ddc_pkg::DDC_PW_ON, busy: 2'h0, bsy: 1'b0, viol: 1'b0,
				mr: {`DDC_MR_COUNT{`DDC_MR_RESET}}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cmd           = st_r.cmd;
	assign cmd_stb       = st_r.stb;
	assign cmd_bank      = st_r.bank;
	assign cmd_addr      = st_r.addr;
	assign pwr_state     = st_r.pwr;
	assign burst_busy    = st_r.bsy;
	assign cmd_violation = st_r.viol;

	for (genvar i = 0; i < `DDC_MR_COUNT; i++) begin : g_mr
		assign mode_reg[i] = st_r.mr[i];
	end

endmodule

// File: core/ddc_if.sv
// Command and address pins between controller and memory device
`timescale 1ns/10ps
`include "ddc_defs.svh"

interface ddc_if;
	logic                         cs_n;
	logic                         ras_n;
	logic                         cas_n;
	logic                         we_n;
	logic                         cke;
	logic [`DDC_BANK_BITS-1:0]    ba;
	logic [`DDC_ADDR_BITS-1:0]    addr;

	modport ctrl (output cs_n, output ras_n, output cas_n, output we_n,
		output cke, output ba, output addr);
	modport dev (input cs_n, input ras_n, input cas_n, input we_n,
		input cke, input ba, input addr);
endinterface

// File: core/ddc_pkg.sv
// Types shared by both ends of the command link
package ddc_pkg;

	typedef enum logic [3:0] {
		DDC_NOP        = 4'h0,
		DDC_DESEL      = 4'h1,
		DDC_MODE_LOAD  = 4'h2,
		DDC_REFRESH    = 4'h3,
		DDC_SREF_ENTER = 4'h4,
		DDC_PD_ENTER   = 4'h5,
		DDC_LOW_EXIT   = 4'h6,
		DDC_ACTIVATE   = 4'h7,
		DDC_PRE_BANK   = 4'h8,
		DDC_PRE_ALL    = 4'h9,
		DDC_READ       = 4'ha,
		DDC_READ_AP    = 4'hb,
		DDC_WRITE      = 4'hc,
		DDC_WRITE_AP   = 4'hd,
		DDC_ILLEGAL    = 4'he
	} ddc_cmd_t;

	typedef enum logic [2:0] {
		DDC_PW_ON   = 3'b001,
		DDC_PW_DOWN = 3'b010,
		DDC_PW_SREF = 3'b100
	} ddc_pwr_t;

endpackage

// File: sim/ddc_assertions.sv
// Pin-level checks on the command link
`timescale 1ns/10ps
`include "ddc_defs.svh"
module ddc_assertions #(
	parameter int PD_MAX_CLKS = `DDC_PD_MAX_CLKS
) (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic        cke,
	input wire logic [2:0]  ba,
	input wire logic [13:0] addr
);
	logic [2:0] rcw;
	logic       pd_r;
	int         pd_cnt_r;
	assign rcw = {ras_n, cas_n, we_n};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Power-down stay counter; self refresh is not limited
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pd_r <= 1'b0;
			pd_cnt_r <= 0;
		end else if (cke) begin
			pd_r <= 1'b0;
			pd_cnt_r <= 0;
		end else begin
			pd_r <= (pd_cnt_r == 0) ? (cs_n || rcw == 3'b111) : pd_r;
			pd_cnt_r <= pd_cnt_r + 1;
		end
	end
	sequence s_col;
		cke && !cs_n && rcw[2:1] == 2'b10;
	endsequence
	sequence s_quiet;
		cs_n && cke;
	endsequence
	property p_burst_gap;
		s_col |=> cs_n;
	endproperty
	a_burst_gap: assert property (p_burst_gap) else $error("command inside burst");
	property p_burst_cke;
		s_col |=> s_quiet;
	endproperty
	a_burst_cke: assert property (p_burst_cke) else $error("cke moved in burst");
	property p_fall_enc;
		$fell(cke) |-> cs_n || rcw == 3'b111 || rcw == 3'b001;
	endproperty
	a_fall_enc: assert property (p_fall_enc) else $error("bad low power entry");
	property p_rise_enc;
		$rose(cke) |-> cs_n || rcw == 3'b111;
	endproperty
	a_rise_enc: assert property (p_rise_enc) else $error("bad low power exit");
	property p_low_quiet;
		!cke && !$past(cke) |-> cs_n;
	endproperty
	a_low_quiet: assert property (p_low_quiet) else $error("command while cke low");
	property p_low_cmd;
		!cke && !cs_n && rcw != 3'b111 |-> rcw == 3'b001 && $past(cke);
	endproperty
	a_low_cmd: assert property (p_low_cmd) else $error("command with cke low");
	property p_no_reserved;
		cke && $past(cke) && !cs_n |-> rcw != 3'b110;
	endproperty
	a_no_reserved: assert property (p_no_reserved) else $error("reserved encoding");
	property p_pd_limit;
		pd_r |-> pd_cnt_r <= PD_MAX_CLKS + 2;
	endproperty
	a_pd_limit: assert property (p_pd_limit) else $error("power-down too long");
endmodule

// File: sim/tb_sdram_command_decoder.sv
// Self-checking bench for both ends of the command link
`timescale 1ns/10ps
`include "ddc_defs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_sdram_command_decoder;
	typedef struct {ddc_pkg::ddc_cmd_t c; logic [2:0] b, bm; logic [13:0] a, am;} ddc_exp_t;
	localparam int PD_MAX = 8;
	logic ref_clk = 0, arst_n = 0, req_valid = 0, req_ready, pd_forced, stb, busy, viol, viol2;
	ddc_pkg::ddc_cmd_t req_cmd = ddc_pkg::DDC_NOP, cmd;
	logic [2:0] req_bank = 0, cbank;
	logic [13:0] req_addr = 0, caddr, mreg [4];
	ddc_pkg::ddc_pwr_t cpwr, dpwr;
	int failures = 0, samples_checked = 0, seed = 96517, n2 = 0, n;
	ddc_exp_t q[$];
	ddc_pkg::ddc_cmd_t tc[9] = '{ddc_pkg::DDC_MODE_LOAD, ddc_pkg::DDC_REFRESH,
		ddc_pkg::DDC_ACTIVATE, ddc_pkg::DDC_PRE_BANK, ddc_pkg::DDC_PRE_ALL, ddc_pkg::DDC_READ,
		ddc_pkg::DDC_READ_AP, ddc_pkg::DDC_WRITE, ddc_pkg::DDC_WRITE_AP};
	logic [13:0] tm[9] = '{14'h3fff, 0, 14'h3fff, 14'h0400, 14'h0400, 14'h3fff, 14'h3fff,
		14'h3fff, 14'h3fff};
	logic [2:0] tbm[9] = '{3'h7, 0, 3'h7, 3'h7, 0, 3'h7, 3'h7, 3'h7, 3'h7};
	logic [1:0] tf[9] = '{0, 0, 0, 1, 2, 1, 2, 1, 2};
	always #20 ref_clk = ~ref_clk;
	ddc_if lk();
	ddc_if lk2();
	ddc_ctrl #(.PD_MAX_CLKS(PD_MAX)) ddc_ctrl_inst(.ref_clk, .arst_n, .pins(lk.ctrl),
		.req_valid, .req_cmd, .req_bank, .req_addr, .req_ready, .pwr_state(cpwr), .pd_forced);
	ddc_dev ddc_dev_inst(.ref_clk, .arst_n, .pins(lk.dev), .cmd, .cmd_stb(stb),
		.cmd_bank(cbank), .cmd_addr(caddr), .pwr_state(dpwr), .burst_busy(busy),
		.cmd_violation(viol), .mode_reg(mreg));
	// Second device faces a rogue driver, so faults never reach the checked link
	ddc_dev ddc_dev_inst_b(.ref_clk, .arst_n, .pins(lk2.dev), .cmd(), .cmd_stb(),
		.cmd_bank(), .cmd_addr(), .pwr_state(), .burst_busy(), .cmd_violation(viol2),
		.mode_reg());
	ddc_assertions #(.PD_MAX_CLKS(PD_MAX)) ddc_assertions_inst(.ref_clk, .arst_n,
		.cs_n(lk.cs_n), .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .cke(lk.cke),
		.ba(lk.ba), .addr(lk.addr));
	always @(posedge ref_clk) if (arst_n) begin
		if (viol2) n2++;
		`CHK(viol, 1'b0)
		if (stb && !(cmd inside {ddc_pkg::DDC_NOP, ddc_pkg::DDC_DESEL, ddc_pkg::DDC_LOW_EXIT}))
		begin
			if (q.size() == 0) `CHK(cmd, ddc_pkg::DDC_NOP)
			else begin
				`CHK(cmd, q[0].c)
				`CHK(cbank & q[0].bm, q[0].b & q[0].bm)
				`CHK(caddr & q[0].am, q[0].a & q[0].am)
				`CHK(busy, is_burst(q[0].c))
				if (cmd === ddc_pkg::DDC_MODE_LOAD) `CHK(mreg[q[0].b[1:0]], q[0].a)
				void'(q.pop_front());
			end
		end
	end
	// Only column commands open a burst window
	function automatic logic is_burst(ddc_pkg::ddc_cmd_t c);
		return c inside {ddc_pkg::DDC_READ, ddc_pkg::DDC_READ_AP, ddc_pkg::DDC_WRITE,
			ddc_pkg::DDC_WRITE_AP};
	endfunction
	task automatic final_report();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Valid stays up between calls so back-to-back requests need no gap
	task automatic issue(ddc_pkg::ddc_cmd_t c, logic [2:0] b, bm, logic [13:0] a, am,
		logic [1:0] f);
		n = 0;
		req_valid <= 1'b1;
		req_cmd <= c;
		req_bank <= b;
		req_addr <= a;
		do begin @(posedge ref_clk); n++; end while (!req_ready && n < 16);
		if (n == 16) begin failures++; final_report(); end
		if (f != 0) a[10] = f[1];
		if (!(c inside {ddc_pkg::DDC_NOP, ddc_pkg::DDC_LOW_EXIT, ddc_pkg::DDC_DESEL,
			ddc_pkg::DDC_ILLEGAL}))
			q.push_back('{c, b, bm, a, am});
	endtask
	task automatic idle(int k);
		req_valid <= 1'b0;
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic rog(logic [3:0] v, int k);
		{lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n} <= v;
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic lowp(ddc_pkg::ddc_cmd_t c, ddc_pkg::ddc_pwr_t p);
		issue(c, 0, 0, 0, 0, 0);
		idle(3);
		`CHK(dpwr, p)
		`CHK(cpwr, p)
	endtask
	initial begin
		{lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n, lk2.cke, lk2.ba, lk2.addr} = {5'h1f, 17'h0};
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		`CHK(mreg[3], 14'h0000)
		for (int r = 0; r < 3; r++) for (int i = 0; i < 9; i++)
			issue(tc[i], 3'($random(seed)), tbm[i], 14'($random(seed)), tm[i], tf[i]);
		// Idle codes from the user must reach the device only as NOP or deselect
		issue(ddc_pkg::DDC_NOP, 0, 0, 0, 0, 0);
		issue(ddc_pkg::DDC_DESEL, 0, 0, 0, 0, 0);
		issue(ddc_pkg::DDC_ILLEGAL, 0, 0, 0, 0, 0);
		idle(4);
		`CHK(q.size(), 0)
		$display("commands done");
		lowp(ddc_pkg::DDC_PD_ENTER, ddc_pkg::DDC_PW_DOWN);
		lowp(ddc_pkg::DDC_LOW_EXIT, ddc_pkg::DDC_PW_ON);
		lowp(ddc_pkg::DDC_SREF_ENTER, ddc_pkg::DDC_PW_SREF);
		lowp(ddc_pkg::DDC_LOW_EXIT, ddc_pkg::DDC_PW_ON);
		issue(ddc_pkg::DDC_PD_ENTER, 0, 0, 0, 0, 0);
		idle(1);
		n = 0;
		while (!pd_forced && n < 40) begin @(posedge ref_clk); n++; end
		if (n == 40) begin failures++; final_report(); end
		`CHK(n <= PD_MAX + 3, 1'b1)
		idle(3);
		`CHK(dpwr, ddc_pkg::DDC_PW_ON)
		$display("power done");
		rog(4'h5, 1);
		rog(4'h4, 1);
		rog(4'hf, 4);
		`CHK(n2, 1)
		rog(4'h6, 1);
		rog(4'hf, 4);
		`CHK(n2, 2)
		$display("faults done");
		final_report();
	end
endmodule
